// [design/vtp_apb_regs.sv]
`timescale 1ns/10ps
module vtp_apb_regs
  import vtp_pkg::*;
(
  // apb slave
  input  logic        pclk,
  input  logic        presetn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // configuration towards the generator
  vtp_cfg_if.regs     cfg
);
  logic [12:0] ctrl_reg;
  logic [19:0] recf_reg;
  logic [19:0] recr_reg;
  logic [11:0] plat_reg;
  logic [11:0] rowh_reg;
  logic [11:0] picw_reg;
  logic        wr_en;

  function automatic logic mapped(input logic [7:0] a);
    return a == OFF_CTRL || a == OFF_RECF || a == OFF_RECR || a == OFF_PLAT ||
           a == OFF_ROWH || a == OFF_PICW || a == OFF_STATUS;
  endfunction

  // zero wait states: access phase always completes at once
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign wr_en   = psel & penable & pwrite;

  // software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      recf_reg <= RECF_RST;
      recr_reg <= RECR_RST;
      plat_reg <= PLAT_RST;
      rowh_reg <= ROWH_RST;
      picw_reg <= PICW_RST;
    end else if (wr_en) begin
      case (paddr)
        OFF_CTRL: ctrl_reg <= pwdata[12:0];
        OFF_RECF: recf_reg <= pwdata[19:0];
        OFF_RECR: recr_reg <= pwdata[19:0];
        OFF_PLAT: plat_reg <= pwdata[11:0];
        OFF_ROWH: rowh_reg <= pwdata[11:0];
        OFF_PICW: picw_reg <= pwdata[11:0];
        default: ;
      endcase
    end
  end

  // read data captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFF_CTRL:   prdata <= {19'h00000, ctrl_reg};
        OFF_RECF:   prdata <= {12'h000, recf_reg};
        OFF_RECR:   prdata <= {12'h000, recr_reg};
        OFF_PLAT:   prdata <= {20'h00000, plat_reg};
        OFF_ROWH:   prdata <= {20'h00000, rowh_reg};
        OFF_PICW:   prdata <= {20'h00000, picw_reg};
        OFF_STATUS: prdata <= {15'h0000, cfg.refused, cfg.frame_cnt};
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  // field split towards the generator
  assign cfg.pat        = vtp_pat_t'(ctrl_reg[CTL_PAT_LSB +: 4]);
  assign cfg.d12        = ctrl_reg[CTL_D12];
  assign cfg.ycc        = ctrl_reg[CTL_YCC];
  assign cfg.ext_en     = ctrl_reg[CTL_EXT];
  assign cfg.enh_en     = ctrl_reg[CTL_ENH];
  assign cfg.sel        = ctrl_reg[CTL_SEL_LSB +: 4];
  assign cfg.pct75      = ctrl_reg[CTL_PCT75];
  assign cfg.recip_full = recf_reg;
  assign cfg.recip_ramp = recr_reg;
  assign cfg.plat       = plat_reg;
  assign cfg.rowh       = rowh_reg;
  assign cfg.picw       = picw_reg;
endmodule

// [design/vtp_cfg_if.sv]
`timescale 1ns/10ps
interface vtp_cfg_if;
  import vtp_pkg::*;
  vtp_pat_t    pat;
  logic        d12;
  logic        ycc;
  logic        ext_en;
  logic        enh_en;
  logic [3:0]  sel;
  logic        pct75;
  logic [19:0] recip_full;
  logic [19:0] recip_ramp;
  logic [11:0] plat;
  logic [11:0] rowh;
  logic [11:0] picw;
  logic [15:0] frame_cnt;
  logic        refused;
  modport regs (output pat, d12, ycc, ext_en, enh_en, sel, pct75, recip_full,
                recip_ramp, plat, rowh, picw, input frame_cnt, refused);
  modport core (input pat, d12, ycc, ext_en, enh_en, sel, pct75, recip_full,
                recip_ramp, plat, rowh, picw, output frame_cnt, refused);
endinterface

// [design/vtp_pattern_gen.sv]
`timescale 1ns/10ps
// Function
// - stairs: equal steps, same code every channel in RGB
// - valid 10-bit ranges: Y 64-940, C 64-960
// - stairs run 62 to 942 or 962
// - valid ramp matrix plus each ramp alone
// - Y ramp spans valid luma range
// - Cb ramp yellow-blue, Cr ramp cyan-red
// - three-channel ramp with blank and valid plateaus
// - limit ramp spans 4-1019 or 16-4079
// - limit ramp plateaus: blank, valid, limit
// - shallow matrix holds codes 16 or 4 pixels
// - shallow rows overlap at their ends
// - colour rows walk the six adjacent hues
// - colour rows: saturation then value steps
// - last colour row is monochrome
// - mono flats: black, half, white
// - six colour flats at full value
// - extended set adds 10% mono steps
// - enhanced set adds 75% colour flats
module vtp_pattern_gen
  import vtp_pkg::*;
#(
  parameter int POS_W = 12,
  parameter int ROW_W = 8
) (
  // clock and reset
  input  logic             pclk,
  input  logic             presetn,
  // apb slave
  input  logic             psel,
  input  logic             penable,
  input  logic             pwrite,
  input  logic [7:0]       paddr,
  input  logic [31:0]      pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // raster position from the timing source
  input  logic [POS_W-1:0] h_index,
  input  logic [POS_W-1:0] v_index,
  input  logic             active,
  // pixel codes: ch0 Y/G, ch1 Cb/B, ch2 Cr/R
  output logic [11:0]      out_ch0,
  output logic [11:0]      out_ch1,
  output logic [11:0]      out_ch2,
  output logic             out_valid
);
  // the arithmetic below is sized for 12-bit positions at most
  if (POS_W < 8 || POS_W > 12) begin : g_bad_pos
    $error("vtp_pattern_gen: POS_W must be 8..12");
  end
  if (ROW_W < 3 || ROW_W > 12) begin : g_bad_row
    $error("vtp_pattern_gen: ROW_W must be 3..12");
  end

  vtp_cfg_if cfg ();

  logic [11:0] x;
  logic [11:0] blk, vhi, chi, cmid, ymid, llo, lhi;
  logic [11:0] frac_full, code_full, frac_mid, code_mid;
  logic [11:0] pos_mid, rlo, rhi, cr_lo, cr_hi;
  logic [11:0] lr_reg, lr_next;
  logic [ROW_W-1:0] row_reg, row_next;
  logic [15:0] frame_reg;
  logic        line_start;
  logic [13:0] p1, p2, p3, xr;
  logic [1:0]  lslot, rslot;
  logic        is_lim;
  logic [11:0] side_code;
  logic [3:0]  sidx;
  logic [11:0] st_y, st_c;
  logic [3:0]  hsh;
  logic [11:0] sh_step, sh_code;
  logic [19:0] sh_sum;
  logic [14:0] hue6;
  logic [11:0] hf, hfn, br, bg, bb;
  logic [2:0]  cm_row;
  logic [11:0] mono_c, col_lvl;
  logic [2:0]  col_rgb;
  logic        mono_ok, col_ok;
  logic [11:0] n0, n1, n2;
  logic        refused;

  assign x = 12'(h_index);

  // register file over apb
  vtp_apb_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .cfg     (cfg.regs)
  );

  // depth-scaled reference levels
  // valid range ends and mid codes, then limit ends
  assign blk  = lvl(BLACK10, cfg.d12);
  assign vhi  = lvl(WHITE10, cfg.d12);
  assign chi  = lvl(CMAX10, cfg.d12);
  assign cmid = lvl(CMID10, cfg.d12);
  assign ymid = lvl(YMID10, cfg.d12);
  assign llo  = cfg.d12 ? LIM12_LO : LIM10_LO;
  assign lhi  = cfg.d12 ? LIM12_HI : LIM10_HI;

  // full-width ramp: drives the stairs, the valid ramps and matrix, and the colour matrix
  always_comb begin
    cr_lo = blk;
    cr_hi = vhi;
    if (cfg.pat == PAT_CB_RAMP || cfg.pat == PAT_CR_RAMP ||
        (cfg.pat == PAT_VALID_MX && row_next != '0)) begin
      cr_hi = chi;
    end
  end

  vtp_ramp u_ramp_full (
    .pos   (x),
    .recip (cfg.recip_full),
    .lo    (cr_lo),
    .hi    (cr_hi),
    .frac  (frac_full),
    .code  (code_full)
  );

  // ramp between the side plateaus
  assign is_lim  = (cfg.pat == PAT_LIMIT_RAMP);
  assign rlo     = is_lim ? llo : blk;
  assign rhi     = is_lim ? lhi : vhi;
  assign pos_mid = (lslot == 2'd3) ? 12'(14'(x) - p3) : 12'h000;

  vtp_ramp u_ramp_mid (
    .pos   (pos_mid),
    .recip (cfg.recip_ramp),
    .lo    (rlo),
    .hi    (rhi),
    .frac  (),
    .code  (code_mid)
  );

  // row tracking for the matrices; the first pixel of a line already
  // sees the new row because the next value is used directly
  assign line_start = active && (x == 12'h000);

  always_comb begin
    lr_next  = lr_reg;
    row_next = row_reg;
    if (line_start) begin
      if (v_index == '0) begin
        lr_next  = 12'h000;
        row_next = '0;
      end else if (13'(lr_reg) + 13'h0001 >= 13'(cfg.rowh)) begin
        lr_next = 12'h000;
        if (row_reg != '1) begin
          row_next = row_reg + 1'b1;
        end
      end else begin
        lr_next = lr_reg + 12'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lr_reg  <= 12'h000;
      row_reg <= '0;
    end else begin
      lr_reg  <= lr_next;
      row_reg <= row_next;
    end
  end

  // frame counter for status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_reg <= 16'h0000;
    end else if (line_start && v_index == '0) begin
      frame_reg <= frame_reg + 16'h0001;
    end
  end
  assign cfg.frame_cnt = frame_reg;
  assign cfg.refused   = refused;

  // side plateaus: slot 0 outermost, slot 3 means inside the ramp
  assign p1 = 14'(cfg.plat);
  assign p2 = 14'(cfg.plat) + 14'(cfg.plat);
  assign p3 = p2 + 14'(cfg.plat);
  assign xr = (x < cfg.picw) ? 14'(cfg.picw - x - 12'h001) : 14'h0000;

  function automatic logic [1:0] slot(input logic [13:0] d, input logic [13:0] a,
                                      input logic [13:0] b, input logic [13:0] c);
    return (d < a) ? 2'd0 : (d < b) ? 2'd1 : (d < c) ? 2'd2 : 2'd3;
  endfunction

  assign lslot = slot(14'(x), p1, p2, p3);
  assign rslot = slot(xr, p1, p2, p3);

  always_comb begin
    side_code = code_mid;
    if (rslot != 2'd3) begin
      side_code = (rslot == 2'd0) ? blk : (rslot == 2'd2 && is_lim) ? lhi : vhi;
    end else if (lslot != 2'd3) begin
      side_code = (lslot == 2'd2 && is_lim) ? llo : blk;
    end
  end

  assign sidx = (cfg.pat == PAT_STAIR10) ? 4'((16'(frac_full) * 16'd11) >> 12)
                                         : 4'((16'(frac_full) * 16'd6) >> 12);
  always_comb begin
    if (cfg.pat == PAT_STAIR10) begin
      st_y = 12'(lvl(STLO10, cfg.d12) + 12'(sidx) * lvl(STY10_10, cfg.d12));
      st_c = 12'(lvl(STLO10, cfg.d12) + 12'(sidx) * lvl(STC10_10, cfg.d12));
    end else begin
      st_y = 12'(lvl(STLO10, cfg.d12) + 12'(sidx) * lvl(STY5_10, cfg.d12));
      st_c = 12'(lvl(STLO10, cfg.d12) + 12'(sidx) * lvl(STC5_10, cfg.d12));
    end
  end

  // hold each code 16 or 4 pixels
  // next row restarts a few codes back
  assign hsh     = cfg.d12 ? HOLD12_SH : HOLD10_SH;
  assign sh_step = (cfg.picw >> hsh) - OVL_CODES;
  assign sh_sum  = 20'(llo) + 20'(row_next) * 20'(sh_step) + 20'(x >> hsh);
  assign sh_code = (sh_sum > 20'(lhi)) ? lhi : sh_sum[11:0];

  assign hue6 = 15'(frac_full) * 15'd6;
  assign hf   = hue6[11:0];
  assign hfn  = FULL_FRAC - hf;
  always_comb begin
    case (hue6[14:12])
      3'd0:    begin br = FULL_FRAC; bg = hf;        bb = 12'h000;   end
      3'd1:    begin br = hfn;       bg = FULL_FRAC; bb = 12'h000;   end
      3'd2:    begin br = 12'h000;   bg = FULL_FRAC; bb = hf;        end
      3'd3:    begin br = hf;        bg = hfn;       bb = FULL_FRAC; end
      3'd4:    begin br = hfn;       bg = 12'h000;   bb = FULL_FRAC; end
      default: begin br = hf;        bg = 12'h000;   bb = hfn;       end
    endcase
  end

  assign cm_row = (row_next > ROW_W'(7)) ? 3'd7 : 3'(row_next);

  function automatic logic [11:0] shade(input logic [11:0] c, input logic [2:0] r,
                                        input logic [11:0] m);
    logic [14:0] t;
    t = 15'h0000;
    if (r < 3'd3) begin
      t = 15'(3'(r + 3'd1)) * 15'(FULL_FRAC - c);
      return FULL_FRAC - 12'(t >> 2);
    end else if (r < 3'd7) begin
      t = 15'(3'(3'd7 - r)) * 15'(c);
      return 12'(t >> 2);
    end
    return m;
  endfunction

  // base levels 0, 5, 10 tenths
  // other tenths need the extended set
  assign mono_c  = 12'((16'(cfg.sel) * 16'(FULL_FRAC)) / 16'd10);
  assign mono_ok = (cfg.sel <= 4'd10) &&
                   (cfg.ext_en || cfg.sel == 4'd0 || cfg.sel == 4'd5 ||
                    cfg.sel == 4'd10);

  always_comb begin
    case (cfg.sel)
      4'd0:    col_rgb = 3'b100;
      4'd1:    col_rgb = 3'b010;
      4'd2:    col_rgb = 3'b001;
      4'd3:    col_rgb = 3'b011;
      4'd4:    col_rgb = 3'b101;
      4'd5:    col_rgb = 3'b110;
      default: col_rgb = 3'b000;
    endcase
  end
  assign col_ok  = (cfg.sel <= 4'd5) && (!cfg.pct75 || cfg.enh_en);
  assign col_lvl = cfg.pct75 ? P75_FRAC : FULL_FRAC;

  // pattern select; refused selections show black
  always_comb begin
    n0      = blk;
    n1      = cfg.ycc ? cmid : blk;
    n2      = cfg.ycc ? cmid : blk;
    refused = 1'b0;
    case (cfg.pat)
      PAT_FLAT_MONO: begin
        refused = ~mono_ok;
        if (mono_ok) begin
          n0 = fmap(mono_c, blk, vhi);
          n1 = cfg.ycc ? cmid : n0;
          n2 = cfg.ycc ? cmid : n0;
        end
      end
      PAT_FLAT_COL: begin
        refused = ~col_ok;
        if (col_ok) begin
          n0 = col_rgb[1] ? fmap(col_lvl, blk, vhi) : blk;
          n1 = col_rgb[0] ? fmap(col_lvl, blk, vhi) : blk;
          n2 = col_rgb[2] ? fmap(col_lvl, blk, vhi) : blk;
        end
      end
      PAT_STAIR5, PAT_STAIR10: begin
        n0 = st_y;
        n1 = cfg.ycc ? st_c : st_y;
        n2 = cfg.ycc ? st_c : st_y;
      end
      // three bands, luma then Cb then Cr
      PAT_VALID_MX: begin
        if (row_next == '0) begin
          n0 = code_full;
        end else if (row_next == ROW_W'(1)) begin
          n0 = ymid;
          n1 = code_full;
        end else begin
          n0 = ymid;
          n2 = code_full;
        end
      end
      PAT_Y_RAMP: begin
        n0 = code_full;
      end
      PAT_CB_RAMP: begin
        n0 = ymid;
        n1 = code_full;
      end
      PAT_CR_RAMP: begin
        n0 = ymid;
        n2 = code_full;
      end
      PAT_CH3_RAMP, PAT_LIMIT_RAMP: begin
        n0 = side_code;
        n1 = side_code;
        n2 = side_code;
      end
      PAT_SHALLOW: begin
        n0 = sh_code;
        n1 = sh_code;
        n2 = sh_code;
      end
      PAT_COLOR_MX: begin
        n0 = fmap(shade(bg, cm_row, frac_full), blk, vhi);
        n1 = fmap(shade(bb, cm_row, frac_full), blk, vhi);
        n2 = fmap(shade(br, cm_row, frac_full), blk, vhi);
      end
      default: refused = 1'b1;
    endcase
    if (!active) begin
      n0 = blk;
      n1 = cfg.ycc ? cmid : blk;
      n2 = cfg.ycc ? cmid : blk;
    end
  end

  // one cycle from position to codes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ch0   <= 12'h000;
      out_ch1   <= 12'h000;
      out_ch2   <= 12'h000;
      out_valid <= 1'b0;
    end else begin
      out_ch0   <= n0;
      out_ch1   <= n1;
      out_ch2   <= n2;
      out_valid <= active;
    end
  end
endmodule

// [design/vtp_pkg.sv]
package vtp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_RECF   = 8'h04;
  localparam logic [7:0] OFF_RECR   = 8'h08;
  localparam logic [7:0] OFF_PLAT   = 8'h0C;
  localparam logic [7:0] OFF_ROWH   = 8'h10;
  localparam logic [7:0] OFF_PICW   = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // control field positions
  localparam int CTL_PAT_LSB = 0;
  localparam int CTL_D12     = 4;
  localparam int CTL_YCC     = 5;
  localparam int CTL_EXT     = 6;
  localparam int CTL_ENH     = 7;
  localparam int CTL_SEL_LSB = 8;
  localparam int CTL_PCT75   = 12;
  localparam int CTL_W       = 13;
  localparam int STA_REFUSED = 16;
  // reset values
  localparam logic [12:0] CTRL_RST = 13'h0020;
  localparam logic [19:0] RECF_RST = 20'h02222;
  localparam logic [19:0] RECR_RST = 20'h02AAA;
  localparam logic [11:0] PLAT_RST = 12'h040;
  localparam logic [11:0] ROWH_RST = 12'h087;
  localparam logic [11:0] PICW_RST = 12'h780;
  // 10-bit reference codes, then the limit codes for both depths
  localparam logic [9:0] BLACK10   = 10'h040;
  localparam logic [9:0] WHITE10   = 10'h3AC;
  localparam logic [9:0] CMAX10    = 10'h3C0;
  localparam logic [9:0] CMID10    = 10'h200;
  localparam logic [9:0] YMID10    = 10'h1F6;
  localparam logic [9:0] STLO10    = 10'h03E;
  localparam logic [9:0] STYHI10   = 10'h3AE;
  localparam logic [9:0] STCHI10   = 10'h3C2;
  localparam logic [9:0] STY5_10   = 10'((STYHI10 - STLO10) / 5);
  localparam logic [9:0] STY10_10  = 10'((STYHI10 - STLO10) / 10);
  localparam logic [9:0] STC5_10   = 10'((STCHI10 - STLO10) / 5);
  localparam logic [9:0] STC10_10  = 10'((STCHI10 - STLO10) / 10);
  localparam logic [11:0] LIM10_LO = 12'h004;
  localparam logic [11:0] LIM10_HI = 12'h3FB;
  localparam logic [11:0] LIM12_LO = 12'h010;
  localparam logic [11:0] LIM12_HI = 12'hFEF;
  // shallow ramp hold (log2 pixels) and row overlap in codes
  localparam logic [3:0] HOLD10_SH = 4'h4;
  localparam logic [3:0] HOLD12_SH = 4'h2;
  localparam logic [11:0] OVL_CODES = 12'h008;
  localparam logic [11:0] FULL_FRAC = 12'hFFF;
  localparam logic [11:0] P75_FRAC  = 12'hBFF;

  typedef enum logic [3:0] {
    PAT_FLAT_MONO, PAT_FLAT_COL, PAT_STAIR5, PAT_STAIR10,
    PAT_VALID_MX, PAT_Y_RAMP, PAT_CB_RAMP, PAT_CR_RAMP,
    PAT_CH3_RAMP, PAT_LIMIT_RAMP, PAT_SHALLOW, PAT_COLOR_MX
  } vtp_pat_t;

  // scale a 10-bit code to the selected depth
  function automatic logic [11:0] lvl(input logic [9:0] c, input logic d12);
    return d12 ? {c, 2'b00} : {2'b00, c};
  endfunction

  // map a 12-bit fraction onto lo..hi, reaching hi exactly at full scale
  function automatic logic [11:0] fmap(input logic [11:0] f, input logic [11:0] lo,
                                       input logic [11:0] hi);
    logic [24:0] p;
    p = 25'(f) * 25'(13'(hi - lo) + 13'h001);
    return 12'(lo + 12'(p >> 12));
  endfunction
endpackage

// [design/vtp_ramp.sv]
`timescale 1ns/10ps
module vtp_ramp
  import vtp_pkg::*;
(
  // position and scale
  input  logic [11:0] pos,
  input  logic [19:0] recip,
  // code range
  input  logic [11:0] lo,
  input  logic [11:0] hi,
  // result
  output logic [11:0] frac,
  output logic [11:0] code
);
  logic [31:0] prod;

  // fraction of the span, saturating past the ramp end so it holds at hi
  assign prod = 32'(pos) * 32'(recip);
  assign frac = (prod[31:24] != 8'h00) ? FULL_FRAC : prod[23:12];
  assign code = fmap(frac, lo, hi);
endmodule

// [verif/vtp_pattern_checker.sv]
`timescale 1ns/10ps
module vtp_pattern_checker (
  // apb side
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // video side
  input logic        active,
  input logic [11:0] out_ch0,
  input logic [11:0] out_ch1,
  input logic [11:0] out_ch2,
  input logic        out_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // video path: one cycle of latency, blanking gives black
  // the release edge itself still resets the output flops, so it starts nothing
  chk_valid_rise: assert property (presetn && active |=> out_valid)
    else $error("out_valid missing after active pixel");
  chk_valid_fall: assert property (!active |=> !out_valid)
    else $error("out_valid high after blanking");
  chk_blank_black: assert property (!active |=> (out_ch0 == 12'h040 || out_ch0 == 12'h100))
    else $error("blanking luma not black");
  chk_blank_chroma: assert property (!active |=> out_ch1 == out_ch2)
    else $error("blanking chroma channels differ");
  // nothing may leave the 10-bit lower limit to 12-bit upper limit span
  chk_legal_range: assert property (out_valid |-> (out_ch0 inside {[12'h004:12'hFEF]})
    && (out_ch1 inside {[12'h004:12'hFEF]}) && (out_ch2 inside {[12'h004:12'hFEF]}))
    else $error("pixel code outside legal limits");
  // apb: zero wait states, errors only on unmapped words
  chk_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_err_bad: assert property (psel && penable && (paddr > 8'h18 || paddr[1:0] != 2'h0)
    |-> pslverr)
    else $error("no error on unmapped address");
  chk_err_good: assert property (psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'h0
    |-> !pslverr)
    else $error("error on mapped address");
  chk_bad_read: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

// [verif/vtp_pattern_gen_bench.sv]
`timescale 1ns/10ps
module vtp_pattern_gen_bench;
  import vtp_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] h_index;
  logic [11:0] v_index;
  logic        active;
  logic [11:0] out_ch0;
  logic [11:0] out_ch1;
  logic [11:0] out_ch2;
  logic        out_valid;
  int          bad_count;
  int          checks;
  logic [31:0] rd;
  logic        er;

  vtp_pattern_gen vtp_pattern_gen_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .h_index(h_index), .v_index(v_index),
    .active(active), .out_ch0(out_ch0), .out_ch1(out_ch1), .out_ch2(out_ch2),
    .out_valid(out_valid));
  vtp_raster_model vtp_raster_model_i (.pclk(pclk), .presetn(presetn), .h_index(h_index),
    .v_index(v_index), .active(active));

  // 10 MHz pixel clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    $display("[FAIL] %0t wait ran out", $time);
    give_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen at an access edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) hang();
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait for a raster position, then judge its codes one cycle later
  task automatic px(input int h, input int v, input logic [11:0] e0, e1, e2);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (!(h_index == h && v_index == v && active === 1'b1) && n < 2000);
    if (n >= 2000) hang();
    @(negedge pclk);
    chk(out_ch0, e0);
    chk(out_ch1, e1);
    chk(out_ch2, e2);
  endtask

  // reset values, an unmapped and a misaligned word, then a small picture
  task automatic t_regs();
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, 32'h20);
    apb(1'b0, OFF_PICW, 32'h0);
    chk(rd, 32'h780);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    apb(1'b0, 8'h02, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, OFF_PICW, 32'hF0);
    apb(1'b1, OFF_RECF, 32'h11111);
    apb(1'b1, OFF_RECR, 32'h1C71C);
    apb(1'b1, OFF_PLAT, 32'h10);
    apb(1'b1, OFF_ROWH, 32'h1);
    apb(1'b0, OFF_PLAT, 32'h0);
    chk(rd, 32'h10);
  endtask

  task automatic t_flat_mono();
    px(5, 0, 12'h040, 12'h200, 12'h200);
    apb(1'b1, OFF_CTRL, 32'h520);
    px(5, 0, 12'h1F6, 12'h200, 12'h200);
    apb(1'b1, OFF_CTRL, 32'hA20);
    px(5, 0, 12'h3AC, 12'h200, 12'h200);
    apb(1'b1, OFF_CTRL, 32'h160);
    px(5, 0, 12'h097, 12'h200, 12'h200);
  endtask

  // six hues as red, green, blue bits in select order
  task automatic t_flat_col();
    logic [17:0] hue;
    logic [2:0]  c;
    hue = 18'b100_010_001_011_101_110;
    for (int k = 0; k < 6; k++) begin
      c = hue[17 - 3 * k -: 3];
      apb(1'b1, OFF_CTRL, 32'h1 | (k << 8));
      px(5, 0, c[1] ? 12'h3AC : 12'h040, c[0] ? 12'h3AC : 12'h040,
         c[2] ? 12'h3AC : 12'h040);
    end
    apb(1'b1, OFF_CTRL, 32'h1081);
    px(5, 0, 12'h040, 12'h040, 12'h2D1);
  endtask

  task automatic t_stairs();
    apb(1'b1, OFF_CTRL, 32'h22);
    px(0, 0, 12'h03E, 12'h03E, 12'h03E);
    px(239, 0, 12'h3AE, 12'h3C2, 12'h3C2);
    apb(1'b1, OFF_CTRL, 32'h03);
    px(0, 0, 12'h03E, 12'h03E, 12'h03E);
    px(239, 0, 12'h3AE, 12'h3AE, 12'h3AE);
  endtask

  task automatic t_limit();
    apb(1'b1, OFF_CTRL, 32'h09);
    px(40, 0, 12'h004, 12'h004, 12'h004);
    px(200, 0, 12'h3FB, 12'h3FB, 12'h3FB);
    px(216, 0, 12'h3AC, 12'h3AC, 12'h3AC);
    px(232, 0, 12'h040, 12'h040, 12'h040);
    apb(1'b1, OFF_CTRL, 32'h19);
    px(40, 0, 12'h010, 12'h010, 12'h010);
    px(200, 0, 12'hFEF, 12'hFEF, 12'hFEF);
  endtask

  task automatic t_shallow();
    apb(1'b1, OFF_CTRL, 32'h0A);
    px(15, 0, 12'h004, 12'h004, 12'h004);
    px(16, 0, 12'h005, 12'h005, 12'h005);
    px(112, 0, 12'h00B, 12'h00B, 12'h00B);
    px(8, 1, 12'h00B, 12'h00B, 12'h00B);
    apb(1'b1, OFF_CTRL, 32'h1A);
    px(3, 0, 12'h010, 12'h010, 12'h010);
    px(4, 0, 12'h011, 12'h011, 12'h011);
  endtask

  // valid ramps and matrix, plateau ramp, colour matrix rows 0 and 1
  task automatic t_ramps();
    apb(1'b1, OFF_CTRL, 32'h24);
    px(0, 0, 12'h040, 12'h200, 12'h200);
    px(0, 1, 12'h1F6, 12'h040, 12'h200);
    apb(1'b1, OFF_CTRL, 32'h05);
    px(0, 0, 12'h040, 12'h040, 12'h040);
    apb(1'b1, OFF_CTRL, 32'h26);
    px(239, 0, 12'h1F6, 12'h3BD, 12'h200);
    apb(1'b1, OFF_CTRL, 32'h08);
    px(56, 0, 12'h070, 12'h070, 12'h070);
    px(216, 0, 12'h3AC, 12'h3AC, 12'h3AC);
    apb(1'b1, OFF_CTRL, 32'h0B);
    px(40, 0, 12'h3AC, 12'h2D1, 12'h3AC);
    px(0, 1, 12'h1F6, 12'h1F6, 12'h3AC);
  endtask

  task automatic t_refused();
    apb(1'b1, OFF_CTRL, 32'h0C);
    px(5, 0, 12'h040, 12'h040, 12'h040);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[STA_REFUSED], 1'b1);
  endtask

  // every input defined at time zero, reset held for 16 clocks
  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    bad_count = 0;
    checks    = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_flat_mono();
    t_flat_col();
    t_stairs();
    t_limit();
    t_shallow();
    t_ramps();
    t_refused();
    give_verdict();
  end
endmodule

bind vtp_pattern_gen vtp_pattern_checker vtp_pattern_checker_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .active(active),
  .out_ch0(out_ch0), .out_ch1(out_ch1), .out_ch2(out_ch2), .out_valid(out_valid));

// [verif/vtp_raster_model.sv]
`timescale 1ns/10ps
module vtp_raster_model #(
  parameter int LINE_W = 240,
  parameter int LINE_T = 256,
  parameter int LINES  = 2
) (
  // clock and reset
  input  logic        pclk,
  input  logic        presetn,
  // raster position
  output logic [11:0] h_index,
  output logic [11:0] v_index,
  output logic        active
);
  // fresh position each clock
  // blanking keeps counting so a line always restarts at h 0 with active high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_index <= 12'h000;
      v_index <= 12'h000;
    end else if (h_index == 12'(LINE_T - 1)) begin
      h_index <= 12'h000;
      v_index <= (v_index == 12'(LINES - 1)) ? 12'h000 : v_index + 12'h001;
    end else begin
      h_index <= h_index + 12'h001;
    end
  end
  assign active = (h_index < 12'(LINE_W));
endmodule
